/* File: spcs_bank.sv */
// serial port configuration and status register bank, Avalon-MM slave
// assumes status and cts pins are asynchronous; event inputs come from core_clk logic
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`default_nettype none
module spcs_bank #(
   parameter int TICK_CYCLES = spcs_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire spcs_pkg::spcs_avm_req_t avm_req,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire spcs_pkg::spcs_pvec_t module_status_pin,
   input wire spcs_pkg::spcs_pvec_t cts_pin,
   input wire logic host_is_rs232,
   input wire spcs_pkg::spcs_evt_t port_evt,
   output logic port_c_role,
   output logic port_d_role,
   output var spcs_pkg::spcs_cfg_arr_t port_cfg,
   output var spcs_pkg::spcs_pvec_t half_stop,
   output logic [spcs_pkg::NGRP-1:0] status_summary
);
   spcs_pkg::spcs_state_t q;
   spcs_pkg::spcs_state_t d;
   logic rd_take;
   logic wr_take;
   logic [31:0] wv;
   logic [31:0] rb;
   spcs_pkg::spcs_sreg_t qm;
   spcs_pkg::spcs_sreg_t [spcs_pkg::NGRP-1:0] set_v;
   spcs_pkg::spcs_sreg_t [spcs_pkg::NGRP-1:0] clr_v;
   spcs_pkg::spcs_pvec_t to_set;
   spcs_pkg::spcs_port_cfg_t wcfg;
   logic cfg_hit;
   logic cfg_ok;
   logic err_set;
   logic tick;
   logic floor_ok;
   logic mod_ok;
   logic half_ok;

   function automatic spcs_pkg::spcs_addr_t grp_addr(input int g, input logic en);
      return spcs_pkg::spcs_addr_t'(int'(spcs_pkg::OFS_GRP) + g * int'(spcs_pkg::GRP_STRIDE)
         + (en ? int'(spcs_pkg::OFS_EN) : 0));
   endfunction

   function automatic spcs_pkg::spcs_addr_t port_addr(input spcs_pkg::spcs_addr_t base, input int p);
      return spcs_pkg::spcs_addr_t'(int'(base) + p * int'(spcs_pkg::WORD_BYTES));
   endfunction

   // a single-port query narrows reads, clears and mask writes to one bit
   function automatic spcs_pkg::spcs_sreg_t port_mask(input logic [3:0] sel);
      if (sel != spcs_pkg::QSEL_ALL && sel <= spcs_pkg::QSEL_MAX)
         return spcs_pkg::spcs_sreg_t'(1'b1) << sel;
      return '1;
   endfunction

   function automatic logic rate_ok(input logic rs232, input logic [19:0] r);
      logic ok;
      ok = 1'b0;
      foreach (spcs_pkg::RATE_STD[i])
         if (r == spcs_pkg::RATE_STD[i]) ok = 1'b1;
      foreach (spcs_pkg::RATE_MOD[i])
         if (!rs232 && r == spcs_pkg::RATE_MOD[i]) ok = 1'b1;
      foreach (spcs_pkg::RATE_HS[i])
         if (rs232 && r == spcs_pkg::RATE_HS[i]) ok = 1'b1;
      if (r < spcs_pkg::BAUD_MIN) ok = 1'b0;
      return ok;
   endfunction

   always_comb
   begin
      d = q;
      rb = '0;
      set_v = '0;
      clr_v = '0;
      to_set = '0;
      err_set = 1'b0;
      cfg_hit = 1'b0;
      cfg_ok = 1'b0;
      floor_ok = 1'b1;
      mod_ok = 1'b1;
      half_ok = 1'b1;
      qm = port_mask(q.qsel);
      rd_take = !q.waitreq && avm_req.read;
      wr_take = !q.waitreq && avm_req.write;
      for (int b = 0; b < 4; b++)
         wv[8*b +: 8] = avm_req.byteenable[b] ? avm_req.writedata[8*b +: 8] : q.rdata[8*b +: 8];
      wcfg = spcs_pkg::spcs_port_cfg_t'(wv[spcs_pkg::CFG_W-1:0]);
      // pins pass two flops; the first stage feeds nothing but the second
      d.st_s1 = module_status_pin;
      d.st_s2 = q.st_s1;
      d.st_prev = q.st_s2;
      d.cts_s1 = cts_pin;
      d.cts_s2 = q.cts_s1;
      d.cts_prev = q.cts_s2;
      d.host_s1 = host_is_rs232;
      d.host_s2 = q.host_s1;
      // edges are ignored until the synchronisers hold real pin levels
      if (q.warm != '1)
         d.warm = q.warm + 2'h1;
      tick = (q.presc == spcs_pkg::PRESC_W'(TICK_CYCLES - 1));
      d.presc = tick ? '0 : q.presc + 1'b1;
      for (int p = 1; p <= spcs_pkg::NPORT; p++)
      begin
         if (!port_evt.queue_wait[p] || q.tmo[p] == '0)
            d.tcnt[p] = '0;
         else if (tick && q.tcnt[p] != q.tmo[p])
         begin
            d.tcnt[p] = q.tcnt[p] + 16'h0001;
            to_set[p] = (q.tcnt[p] + 16'h0001 == q.tmo[p]);
         end
      end
      if (q.warm == '1)
      begin
         set_v[spcs_pkg::GRP_MSE][spcs_pkg::NPORT:1] = (q.st_s2 & ~q.st_prev & q.rise)
            | (~q.st_s2 & q.st_prev & q.fall);
         set_v[spcs_pkg::GRP_CTS][spcs_pkg::NPORT:1] = q.cts_s2 ^ q.cts_prev;
      end
      set_v[spcs_pkg::GRP_CE][spcs_pkg::NPORT:1] = port_evt.comm_err;
      set_v[spcs_pkg::GRP_TO][spcs_pkg::NPORT:1] = to_set;
      set_v[spcs_pkg::GRP_OV][spcs_pkg::NPORT:1] = port_evt.overflow;
      set_v[spcs_pkg::GRP_FC][spcs_pkg::NPORT:1] = port_evt.flow_evt;
      set_v[spcs_pkg::GRP_DP][spcs_pkg::NPORT:1] = port_evt.data_pend;
      // readback, also the merge base for partial byte writes
      unique case (avm_req.address)
         spcs_pkg::OFS_CTRL: rb[spcs_pkg::BIT_ROLE_D:spcs_pkg::BIT_ROLE_C] = {q.role_d, q.role_c};
         spcs_pkg::OFS_ERR: rb[0] = q.exec_err;
         spcs_pkg::OFS_QSEL: rb[3:0] = q.qsel;
         spcs_pkg::OFS_SUM: rb[spcs_pkg::NGRP-1:0] = q.summary;
         spcs_pkg::OFS_COND: rb[spcs_pkg::NPORT:1] = q.st_s2 & qm[spcs_pkg::NPORT:1];
         spcs_pkg::OFS_RISE: rb[spcs_pkg::NPORT:1] = q.rise & qm[spcs_pkg::NPORT:1];
         spcs_pkg::OFS_FALL: rb[spcs_pkg::NPORT:1] = q.fall & qm[spcs_pkg::NPORT:1];
         spcs_pkg::OFS_CTSC: rb[spcs_pkg::NPORT:1] = q.cts_s2 & qm[spcs_pkg::NPORT:1];
         default: rb = '0;
      endcase
      for (int g = 0; g < spcs_pkg::NGRP; g++)
      begin
         if (avm_req.address == grp_addr(g, 1'b0))
            rb[spcs_pkg::NPORT:0] = q.sts[g] & qm;
         if (avm_req.address == grp_addr(g, 1'b1))
            rb[spcs_pkg::NPORT:0] = q.en[g] & qm;
      end
      for (int p = 1; p <= spcs_pkg::NPORT; p++)
      begin
         if (avm_req.address == port_addr(spcs_pkg::OFS_CFG, p))
            rb[spcs_pkg::CFG_W-1:0] = q.cfg[p];
         if (avm_req.address == port_addr(spcs_pkg::OFS_TMO, p))
            rb[15:0] = q.tmo[p];
      end
      // two-phase answer: readback is captured, then the access is taken
      if (q.waitreq && (avm_req.read || avm_req.write))
      begin
         d.waitreq = 1'b0;
         d.rdata = rb;
      end
      else if (!q.waitreq)
         d.waitreq = 1'b1;
      if (rd_take)
      begin
         // only the bits handed out are cleared, so a newer event survives
         for (int g = 0; g < spcs_pkg::NGRP; g++)
            if (avm_req.address == grp_addr(g, 1'b0))
               clr_v[g] = q.rdata[spcs_pkg::NPORT:0] & ~spcs_pkg::SUM_BIT;
      end
      if (wr_take)
      begin
         if (avm_req.address == spcs_pkg::OFS_CTRL)
         begin
            d.role_c = wv[spcs_pkg::BIT_ROLE_C];
            if (wv[spcs_pkg::BIT_ROLE_D] == spcs_pkg::ROLE_GENERAL && q.host_s2)
               err_set = 1'b1;
            else
               d.role_d = wv[spcs_pkg::BIT_ROLE_D];
         end
         if (avm_req.address == spcs_pkg::OFS_QSEL)
            d.qsel = wv[3:0];
         if (avm_req.address == spcs_pkg::OFS_RISE)
            d.rise = (q.rise & ~qm[spcs_pkg::NPORT:1]) | (wv[spcs_pkg::NPORT:1] & qm[spcs_pkg::NPORT:1]);
         if (avm_req.address == spcs_pkg::OFS_FALL)
            d.fall = (q.fall & ~qm[spcs_pkg::NPORT:1]) | (wv[spcs_pkg::NPORT:1] & qm[spcs_pkg::NPORT:1]);
         for (int g = 0; g < spcs_pkg::NGRP; g++)
            if (avm_req.address == grp_addr(g, 1'b1))
               d.en[g] = (q.en[g] & ~qm) | (wv[spcs_pkg::NPORT:0] & qm);
         for (int p = 1; p <= spcs_pkg::NPORT; p++)
         begin
            if (avm_req.address == port_addr(spcs_pkg::OFS_TMO, p))
               d.tmo[p] = wv[15:0];
            if (avm_req.address == port_addr(spcs_pkg::OFS_CFG, p))
            begin
               cfg_hit = 1'b1;
               cfg_ok = rate_ok(p >= spcs_pkg::FIRST_RS232, wcfg.baud)
                  && wcfg.flow <= spcs_pkg::FLOW_XON
                  && wcfg.parity <= spcs_pkg::PAR_SPACE
                  && wcfg.word >= spcs_pkg::WORD_MIN && wcfg.word <= spcs_pkg::WORD_MAX
                  && (wcfg.stop == spcs_pkg::STOP_ONE || wcfg.stop == spcs_pkg::STOP_TWO)
                  && (p >= spcs_pkg::FIRST_RS232 || (wcfg.word == spcs_pkg::WORD_MAX
                  && wcfg.stop == spcs_pkg::STOP_ONE));
               if (cfg_ok)
                  d.cfg[p] = wcfg;
               else
                  err_set = 1'b1;
            end
         end
      end
      for (int g = 0; g < spcs_pkg::NGRP; g++)
      begin
         d.sts[g] = (q.sts[g] & ~clr_v[g]) | set_v[g];
         d.summary[g] = |(q.sts[g] & q.en[g]);
      end
      // summary bits track their source register, never the read
      d.sts[spcs_pkg::GRP_CE][0] = |(q.sts[spcs_pkg::GRP_TO] & q.en[spcs_pkg::GRP_TO]);
      d.sts[spcs_pkg::GRP_FC][0] = |(q.sts[spcs_pkg::GRP_CTS] & q.en[spcs_pkg::GRP_CTS]);
      d.exec_err = (q.exec_err & !(rd_take && avm_req.address == spcs_pkg::OFS_ERR && q.rdata[0]))
         | err_set;
      for (int p = 1; p <= spcs_pkg::NPORT; p++)
      begin
         d.half_stop[p] = d.cfg[p].word == spcs_pkg::WORD_MIN && d.cfg[p].stop == spcs_pkg::STOP_TWO;
         floor_ok = floor_ok && q.cfg[p].baud >= spcs_pkg::BAUD_MIN;
         half_ok = half_ok && (q.half_stop[p] == (q.cfg[p].word == spcs_pkg::WORD_MIN
            && q.cfg[p].stop == spcs_pkg::STOP_TWO));
         if (p < spcs_pkg::FIRST_RS232)
            mod_ok = mod_ok && q.cfg[p].word == spcs_pkg::WORD_MAX && q.cfg[p].stop == spcs_pkg::STOP_ONE;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.waitreq <= 1'b1;
         q.role_c <= spcs_pkg::ROLE_MONITOR;
         q.role_d <= spcs_pkg::ROLE_HOST;
         q.cfg <= {spcs_pkg::NPORT{spcs_pkg::CFG_RESET}};
         q.tmo <= {spcs_pkg::NPORT{spcs_pkg::TMO_RESET_MS}};
      end
      else if (clk_en)
         q <= d;
   end

   assign avm_readdata = q.rdata;
   assign avm_waitrequest = q.waitreq;
   assign port_c_role = q.role_c;
   assign port_d_role = q.role_d;
   assign port_cfg = q.cfg;
   assign half_stop = q.half_stop;
   assign status_summary = q.summary;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   property p_role_reset;
      $rose(reset_n) |-> q.role_c == spcs_pkg::ROLE_MONITOR && q.role_d == spcs_pkg::ROLE_HOST;
   endproperty
   a_role_reset: assert property (p_role_reset) else $error("roles not at reset value");

   property p_port_d_refused;
      clk_en && wr_take && avm_req.address == spcs_pkg::OFS_CTRL && wv[spcs_pkg::BIT_ROLE_D] && q.host_s2
         |=> q.exec_err && $stable(q.role_d);
   endproperty
   a_port_d_refused: assert property (p_port_d_refused) else $error("port D role taken over RS-232 host");

   property p_baud_floor;
      floor_ok;
   endproperty
   a_baud_floor: assert property (p_baud_floor) else $error("baud below floor stored");

   property p_module_frame;
      mod_ok;
   endproperty
   a_module_frame: assert property (p_module_frame) else $error("module port frame changed");

   property p_half_stop;
      half_ok;
   endproperty
   a_half_stop: assert property (p_half_stop) else $error("half stop flag mismatch");

   property p_event_clear;
      clk_en && rd_take && avm_req.address == grp_addr(spcs_pkg::GRP_MSE, 1'b0) && set_v[spcs_pkg::GRP_MSE] == '0
         |=> (q.sts[spcs_pkg::GRP_MSE] & $past(q.rdata[spcs_pkg::NPORT:0])) == '0;
   endproperty
   a_event_clear: assert property (p_event_clear) else $error("returned event bits not cleared");

   property p_timeout_summary;
      clk_en |=> q.sts[spcs_pkg::GRP_CE][0] == $past(|(q.sts[spcs_pkg::GRP_TO] & q.en[spcs_pkg::GRP_TO]));
   endproperty
   a_timeout_summary: assert property (p_timeout_summary) else $error("timeout summary bit wrong");

   property p_cts_live;
      clk_en && q.waitreq && avm_req.read && avm_req.address == spcs_pkg::OFS_CTSC
         |=> q.rdata[spcs_pkg::NPORT:1] == $past(q.cts_s2 & qm[spcs_pkg::NPORT:1]);
   endproperty
   a_cts_live: assert property (p_cts_live) else $error("cts condition not live");

   property p_summary;
      clk_en ##1 clk_en |=> q.summary[spcs_pkg::GRP_DP] == $past(|(q.sts[spcs_pkg::GRP_DP] & q.en[spcs_pkg::GRP_DP]));
   endproperty
   a_summary: assert property (p_summary) else $error("summary does not follow enabled bits");

   property p_wait_one;
      clk_en && !q.waitreq |=> q.waitreq;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");

   property p_cond_live;
      clk_en && q.waitreq && avm_req.read && avm_req.address == spcs_pkg::OFS_COND
         && q.qsel == spcs_pkg::QSEL_ALL |=> q.rdata[spcs_pkg::NPORT:1] == $past(q.st_s2);
   endproperty
   a_cond_live: assert property (p_cond_live) else $error("status condition not live");

   property p_rise_event;
      clk_en && q.warm == '1 && (q.st_s2 & ~q.st_prev & q.rise) != '0 |=> q.sts[spcs_pkg::GRP_MSE] != '0;
   endproperty
   a_rise_event: assert property (p_rise_event) else $error("enabled rising edge left no event");

   property p_enable_write;
      clk_en && wr_take && avm_req.address == grp_addr(spcs_pkg::GRP_TO, 1'b1)
         && q.qsel == spcs_pkg::QSEL_ALL && avm_req.byteenable == 4'hF
         |=> q.en[spcs_pkg::GRP_TO] == $past(avm_req.writedata[spcs_pkg::NPORT:0]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable mask write lost");

   c_cfg_accept: cover property (clk_en && cfg_hit && cfg_ok);
   c_cfg_reject: cover property (clk_en && cfg_hit && !cfg_ok);
   c_event_read: cover property (clk_en && rd_take && clr_v[spcs_pkg::GRP_MSE] != '0);
   c_timeout: cover property (clk_en && to_set != '0);
endmodule
`default_nettype wire

/* File: spcs_pkg.sv */
// package for the serial port configuration and status bank
// assumes one 100 MHz core clock and an Avalon-MM master with 32-bit data
`default_nettype none
package spcs_pkg;
   localparam int NPORT = 13;
   localparam int FIRST_RS232 = 10;
   localparam int NGRP = 7;
   typedef logic [NPORT:1] spcs_pvec_t;
   // bit 0 carries a summary bit in two of the status registers
   typedef logic [NPORT:0] spcs_sreg_t;
   typedef logic [8:0] spcs_addr_t;
   localparam spcs_addr_t OFS_CTRL = 9'h000;
   localparam spcs_addr_t OFS_ERR = 9'h004;
   localparam spcs_addr_t OFS_QSEL = 9'h008;
   localparam spcs_addr_t OFS_SUM = 9'h00C;
   localparam spcs_addr_t OFS_GRP = 9'h020;
   localparam spcs_addr_t GRP_STRIDE = 9'h010;
   localparam spcs_addr_t OFS_EN = 9'h004;
   localparam spcs_addr_t OFS_COND = 9'h090;
   localparam spcs_addr_t OFS_RISE = 9'h094;
   localparam spcs_addr_t OFS_FALL = 9'h098;
   localparam spcs_addr_t OFS_CTSC = 9'h09C;
   localparam spcs_addr_t OFS_CFG = 9'h100;
   localparam spcs_addr_t OFS_TMO = 9'h140;
   localparam spcs_addr_t WORD_BYTES = 9'h004;
   localparam int GRP_MSE = 0;
   localparam int GRP_CE = 1;
   localparam int GRP_TO = 2;
   localparam int GRP_OV = 3;
   localparam int GRP_FC = 4;
   localparam int GRP_CTS = 5;
   localparam int GRP_DP = 6;
   localparam int BIT_ROLE_C = 0;
   localparam int BIT_ROLE_D = 1;
   localparam logic ROLE_MONITOR = 1'b0;
   localparam logic ROLE_HOST = 1'b0;
   localparam logic ROLE_GENERAL = 1'b1;
   localparam logic [3:0] QSEL_ALL = 4'h0;
   localparam logic [3:0] QSEL_MAX = 4'hD;
   localparam spcs_sreg_t SUM_BIT = 14'h0001;
   localparam logic [19:0] BAUD_RESET = 20'h02580;
   localparam logic [19:0] BAUD_MIN = 20'h0006E;
   localparam logic [1:0] FLOW_NONE = 2'h0;
   localparam logic [1:0] FLOW_RTS = 2'h1;
   localparam logic [1:0] FLOW_XON = 2'h2;
   localparam logic [2:0] PAR_NONE = 3'h0;
   localparam logic [2:0] PAR_SPACE = 3'h4;
   localparam logic [3:0] WORD_MIN = 4'h5;
   localparam logic [3:0] WORD_MAX = 4'h8;
   localparam logic [1:0] STOP_ONE = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic [15:0] TMO_RESET_MS = 16'h03E8;
   localparam int TICK_NS = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 17;
   localparam logic [19:0] RATE_STD [0:8] = '{20'h0006E, 20'h0012C, 20'h00258, 20'h004B0, 20'h00960,
      20'h012C0, 20'h02580, 20'h04B00, 20'h09600};
   localparam logic [19:0] RATE_MOD [0:3] = '{20'h0F424, 20'h1312D, 20'h196E7, 20'h2625A};
   localparam logic [19:0] RATE_HS [0:3] = '{20'h0E100, 20'h1C200, 20'h38400, 20'h70800};
   typedef struct packed {
      logic [1:0] stop;
      logic [3:0] word;
      logic [2:0] parity;
      logic [1:0] flow;
      logic [19:0] baud;
   } spcs_port_cfg_t;
   localparam int CFG_W = 31;
   localparam spcs_port_cfg_t CFG_RESET = '{stop: STOP_ONE, word: WORD_MAX, parity: PAR_NONE,
      flow: FLOW_RTS, baud: BAUD_RESET};
   typedef spcs_port_cfg_t [NPORT:1] spcs_cfg_arr_t;
   typedef struct packed {
      logic read;
      logic write;
      spcs_addr_t address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } spcs_avm_req_t;
   typedef struct packed {
      spcs_pvec_t comm_err;
      spcs_pvec_t overflow;
      spcs_pvec_t flow_evt;
      spcs_pvec_t data_pend;
      spcs_pvec_t queue_wait;
   } spcs_evt_t;
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic role_c;
      logic role_d;
      logic exec_err;
      logic [3:0] qsel;
      spcs_sreg_t [NGRP-1:0] sts;
      spcs_sreg_t [NGRP-1:0] en;
      spcs_pvec_t rise;
      spcs_pvec_t fall;
      spcs_pvec_t st_s1;
      spcs_pvec_t st_s2;
      spcs_pvec_t st_prev;
      spcs_pvec_t cts_s1;
      spcs_pvec_t cts_s2;
      spcs_pvec_t cts_prev;
      logic host_s1;
      logic host_s2;
      logic [1:0] warm;
      spcs_cfg_arr_t cfg;
      spcs_pvec_t half_stop;
      logic [NPORT:1][15:0] tmo;
      logic [NPORT:1][15:0] tcnt;
      logic [PRESC_W-1:0] presc;
      logic [NGRP-1:0] summary;
   } spcs_state_t;
endpackage
`default_nettype wire

/* File: spcs_port_model.sv */
// port-side partner: plug-in modules on ports 1-9, RS-232 devices on ports A-D
// assumes the bench changes its controls just after rising edges of core_clk
`default_nettype none
module spcs_port_model (
   input wire logic core_clk,
   input wire spcs_pkg::spcs_pvec_t present,
   input wire spcs_pkg::spcs_pvec_t hold,
   input wire spcs_pkg::spcs_pvec_t status,
   input wire spcs_pkg::spcs_evt_t evt_req,
   output var spcs_pkg::spcs_pvec_t module_status_pin,
   output var spcs_pkg::spcs_pvec_t cts_pin,
   output var spcs_pkg::spcs_evt_t port_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   // module ports sit on a pull-down, RS-232 ports on a pull-up
   always_comb
      for (int p = 1; p <= spcs_pkg::NPORT; p++)
         cts_pin[p] = (p < spcs_pkg::FIRST_RS232) ? present[p] : !hold[p];
   // an absent module leaves its status line low
   assign module_status_pin = status & present;
   always_ff @(posedge core_clk)
      port_evt <= evt_req;
endmodule
`default_nettype wire

/* File: spcs_bank_tb.sv */
// self-checking bench for the serial port configuration and status bank
// assumes the port model on the far side and a 10-cycle timeout tick
`default_nettype none
module spcs_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CFG_DEF = {1'b0, 2'h1, 4'h8, 3'h0, 2'h1, 20'h02580};
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic host_is_rs232 = 1'b0;
   spcs_pkg::spcs_avm_req_t avm_req = '0;
   spcs_pkg::spcs_pvec_t present = 13'h001C;
   spcs_pkg::spcs_pvec_t hold = '0;
   spcs_pkg::spcs_pvec_t status = '0;
   spcs_pkg::spcs_evt_t evt_req = '0;
   spcs_pkg::spcs_pvec_t module_status_pin;
   spcs_pkg::spcs_pvec_t cts_pin;
   spcs_pkg::spcs_evt_t port_evt;
   logic [31:0] avm_readdata;
   logic avm_waitrequest;
   logic port_c_role;
   logic port_d_role;
   spcs_pkg::spcs_cfg_arr_t port_cfg;
   spcs_pkg::spcs_pvec_t half_stop;
   logic [6:0] status_summary;
   logic [31:0] q;
   int n_mismatch = 0;
   int checks = 0;
   spcs_bank #(.TICK_CYCLES(10)) i_spcs_bank (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
      .avm_req(avm_req), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
      .module_status_pin(module_status_pin), .cts_pin(cts_pin), .host_is_rs232(host_is_rs232),
      .port_evt(port_evt), .port_c_role(port_c_role), .port_d_role(port_d_role), .port_cfg(port_cfg),
      .half_stop(half_stop), .status_summary(status_summary));
   spcs_port_model i_spcs_port_model (.core_clk(core_clk), .present(present), .hold(hold), .status(status),
      .evt_req(evt_req), .module_status_pin(module_status_pin), .cts_pin(cts_pin), .port_evt(port_evt));
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // holds the request until waitrequest is sampled low; no latency is assumed
   task automatic acc(input logic wr, input spcs_pkg::spcs_addr_t a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avm_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avm_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         chk("bus answer", 32'h0, 32'h1);
         print_verdict();
      end
      q = avm_readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
   endtask
   task automatic rd(input spcs_pkg::spcs_addr_t a, input logic [31:0] exp, input string nm);
      acc(1'b0, a, 32'h0);
      chk(nm, q, exp);
   endtask
   function automatic spcs_pkg::spcs_addr_t ga(input int g, input int en);
      ga = spcs_pkg::spcs_addr_t'(spcs_pkg::OFS_GRP + spcs_pkg::GRP_STRIDE * g + spcs_pkg::OFS_EN * en);
   endfunction
   function automatic spcs_pkg::spcs_addr_t ca(input int p);
      ca = spcs_pkg::spcs_addr_t'(spcs_pkg::OFS_CFG + spcs_pkg::WORD_BYTES * p);
   endfunction
   function automatic logic [31:0] cb(input logic [19:0] bd);
      cb = {CFG_DEF[31:20], bd};
   endfunction
   function automatic spcs_pkg::spcs_pvec_t pb(input int p);
      pb = '0;
      pb[p] = 1'b1;
   endfunction
   // a refused write must leave the error flag set; only an accepted write is read back
   task automatic tcfg(input int p, input logic [31:0] v, input logic ok);
      acc(1'b1, ca(p), v);
      rd(spcs_pkg::OFS_ERR, {31'h0, !ok}, "exec error");
      if (ok)
         rd(ca(p), v, "port config");
   endtask
   task automatic t_reset();
      rd(spcs_pkg::OFS_CTRL, 32'h0, "roles");
      rd(ca(1), CFG_DEF, "cfg port 1");
      rd(ca(13), CFG_DEF, "cfg port 13");
      chk("port_cfg 5", port_cfg[5], CFG_DEF);
      rd(spcs_pkg::OFS_TMO + 9'h008, 32'h000003E8, "timeout ms");
      rd(spcs_pkg::OFS_RISE, 32'h0, "rise mask");
      rd(spcs_pkg::OFS_FALL, 32'h0, "fall mask");
      acc(1'b1, 9'h1F0, 32'hFFFFFFFF);
      rd(9'h1F0, 32'h0, "unmapped");
   endtask
   task automatic t_roles();
      acc(1'b1, spcs_pkg::OFS_CTRL, 32'h3);
      rd(spcs_pkg::OFS_CTRL, 32'h3, "roles general");
      chk("role pins", {30'h0, port_d_role, port_c_role}, 32'h3);
      host_is_rs232 <= 1'b1;
      acc(1'b1, spcs_pkg::OFS_CTRL, 32'h0);
      acc(1'b1, spcs_pkg::OFS_CTRL, 32'h3);
      rd(spcs_pkg::OFS_ERR, 32'h1, "exec error");
      // the port C bit lands even when the port D half is refused
      rd(spcs_pkg::OFS_CTRL, 32'h1, "roles kept");
      rd(spcs_pkg::OFS_ERR, 32'h0, "error cleared");
      acc(1'b1, spcs_pkg::OFS_CTRL, 32'h1);
      rd(spcs_pkg::OFS_CTRL, 32'h1, "port c general");
      host_is_rs232 <= 1'b0;
   endtask
   task automatic t_baud();
      for (int i = 0; i < 9; i++)
         tcfg(1, cb(spcs_pkg::RATE_STD[i]), 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         tcfg(1, cb(spcs_pkg::RATE_MOD[i]), 1'b1);
         tcfg(1, cb(spcs_pkg::RATE_HS[i]), 1'b0);
         tcfg(10, cb(spcs_pkg::RATE_HS[i]), 1'b1);
         tcfg(10, cb(spcs_pkg::RATE_MOD[i]), 1'b0);
      end
      tcfg(10, cb(20'h0006D), 1'b0);
   endtask
   task automatic t_frame();
      for (int f = 0; f < 3; f++)
         tcfg(11, {CFG_DEF[31:22], f[1:0], CFG_DEF[19:0]}, 1'b1);
      tcfg(11, {CFG_DEF[31:22], 2'h3, CFG_DEF[19:0]}, 1'b0);
      for (int p = 0; p < 5; p++)
         tcfg(11, {CFG_DEF[31:25], p[2:0], CFG_DEF[21:0]}, 1'b1);
      tcfg(11, {CFG_DEF[31:25], 3'h5, CFG_DEF[21:0]}, 1'b0);
      for (int w = 5; w < 9; w++)
         tcfg(12, {3'h2, w[3:0], CFG_DEF[24:0]}, 1'b1);
      tcfg(1, {3'h1, 4'h7, CFG_DEF[24:0]}, 1'b0);
      tcfg(1, {3'h2, 4'h8, CFG_DEF[24:0]}, 1'b0);
      chk("half stop 8 bit", {31'h0, half_stop[12]}, 32'h0);
      tcfg(12, {3'h2, 4'h5, CFG_DEF[24:0]}, 1'b1);
      chk("half stop 5 bit", {31'h0, half_stop[12]}, 32'h1);
   endtask
   task automatic t_pins();
      status <= pb(4);
      hold <= pb(11);
      repeat (4) @(posedge core_clk);
      rd(spcs_pkg::OFS_COND, 32'h00000010, "status condition");
      rd(spcs_pkg::OFS_CTSC, 32'h00003438, "cts condition");
   endtask
   task automatic t_event();
      acc(1'b1, spcs_pkg::OFS_RISE, 32'h28);
      acc(1'b1, spcs_pkg::OFS_FALL, 32'h10);
      status <= pb(3) | pb(5);
      repeat (6) @(posedge core_clk);
      status <= '0;
      repeat (6) @(posedge core_clk);
      acc(1'b1, ga(0, 1), 32'h20);
      // the summary register lags the enable by one cycle
      repeat (2) @(posedge core_clk);
      chk("summary set", {31'h0, status_summary[0]}, 32'h1);
      acc(1'b1, spcs_pkg::OFS_QSEL, 32'h3);
      rd(ga(0, 0), 32'h8, "event port 3");
      acc(1'b1, ga(0, 1), 32'h8);
      acc(1'b1, spcs_pkg::OFS_QSEL, 32'h0);
      rd(ga(0, 1), 32'h28, "enable one bit");
      rd(ga(0, 0), 32'h30, "event rest");
      rd(ga(0, 0), 32'h0, "event cleared");
      chk("summary clear", {31'h0, status_summary[0]}, 32'h0);
   endtask
   task automatic t_timeout();
      acc(1'b1, spcs_pkg::OFS_TMO + 9'h008, 32'h3);
      acc(1'b1, ga(2, 1), 32'h4);
      evt_req.queue_wait <= pb(2);
      repeat (60) @(posedge core_clk);
      evt_req.queue_wait <= '0;
      rd(ga(1, 0), 32'h1, "comm error summary");
      rd(ga(1, 0), 32'h1, "comm error kept");
      chk("timeout summary", {31'h0, status_summary[2]}, 32'h1);
      rd(ga(2, 0), 32'h4, "timeout status");
      rd(ga(2, 0), 32'h0, "timeout cleared");
      rd(ga(1, 0), 32'h0, "comm error follows");
   endtask
   task automatic t_evtregs();
      evt_req <= '{comm_err: pb(6), overflow: pb(7), flow_evt: pb(8), data_pend: pb(9), queue_wait: '0};
      @(posedge core_clk);
      evt_req <= '0;
      repeat (3) @(posedge core_clk);
      rd(ga(1, 0), 32'h40, "comm error");
      rd(ga(3, 0), 32'h80, "overflow");
      rd(ga(4, 0), 32'h100, "flow control");
      rd(ga(6, 0), 32'h200, "data pending");
      foreach (spcs_pkg::RATE_MOD[i])
         rd(ga(i == 0 ? 1 : i == 1 ? 3 : i == 2 ? 4 : 6, 0), 32'h0, "read cleared");
   endtask
   task automatic t_cts();
      acc(1'b0, ga(5, 0), 32'h0);
      acc(1'b1, ga(5, 1), 32'h800);
      hold <= '0;
      repeat (6) @(posedge core_clk);
      rd(ga(4, 0), 32'h1, "cts summary");
      rd(ga(4, 0), 32'h1, "cts summary kept");
      rd(ga(5, 0), 32'h800, "cts change");
      rd(ga(5, 0), 32'h0, "cts change cleared");
      rd(ga(4, 0), 32'h0, "cts summary follows");
   endtask
   initial
   begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset();
      t_roles();
      t_baud();
      t_frame();
      t_pins();
      t_event();
      t_timeout();
      t_evtregs();
      t_cts();
      print_verdict();
   end
endmodule
`default_nettype wire
